// file: hw/chan_map_pkg.sv
// Constants for the channel map register bank
// Summary of operation
// [RULE_01] Map registers are 16 bits wide
// [RULE_02] Channel one map at index 0x11, resets 0x0001
// [RULE_03] Bit 15 enables channel one, default off
// [RULE_04] Enabled channels are sequenced automatically
// [RULE_05] Host writes zero to reserved bit 14
// [RULE_06] Bits 13:12 choose one of four setups
// [RULE_07] Chosen setup configures that channel's conversions
// [RULE_08] Host may share or vary setups per channel
// [RULE_09] Bits 4:0 route negative input, reset input 1
// [RULE_10] Host writes only documented input codes
// [RULE_11] Channel zero enable resets to one
// [RULE_12] Bits 9:5 route positive input, reset input 0
`default_nettype none
package chan_map_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  CH0_INDEX     = 8'h10;
    localparam logic [7:0]  CH1_INDEX     = 8'h11;
    localparam logic [31:0] CH0_ADDR      = {22'h000000, CH0_INDEX, 2'h0};
    localparam logic [31:0] CH1_ADDR      = {22'h000000, CH1_INDEX, 2'h0};
    // Field positions
    localparam int          EN_BIT        = 15;
    localparam int          RSV_BIT       = 14;
    localparam int          SETUP_HI      = 13;
    localparam int          SETUP_LO      = 12;
    localparam int          PLUS_HI       = 9;
    localparam int          PLUS_LO       = 5;
    localparam int          MINUS_HI      = 4;
    localparam int          MINUS_LO      = 0;
    // Writable bits; bit 14 and bits 11:10 read as zero
    localparam logic [15:0] MAP_WMASK     = 16'hB3FF;
    // Reset values
    localparam logic [15:0] CH0_RESET     = 16'h8001;
    localparam logic [15:0] CH1_RESET     = 16'h0001;
    // Documented input codes
    localparam logic [4:0]  IN_LAST       = 5'h04;
    localparam logic [4:0]  IN_REF_POS    = 5'h15;
    localparam logic [4:0]  IN_REF_NEG    = 5'h16;
    // Sequencer states
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CH0, SEQ_CH1} seq_state_t;
endpackage
`default_nettype wire

// file: hw/chan_map_regs.sv
// AHB-Lite channel map register bank with route outputs
`timescale 1ns/100ps
`default_nettype none
module chan_map_regs (
    input  wire logic        hclk,            // Bus clock, 20 MHz
    input  wire logic        hresetn,         // Asynchronous reset, active low
    input  wire logic        hsel,            // Slave select
    input  wire logic [31:0] haddr,           // Byte address
    input  wire logic [1:0]  htrans,          // Transfer type
    input  wire logic        hwrite,          // Write when high
    input  wire logic [2:0]  hsize,           // Only words are expected
    input  wire logic [31:0] hwdata,          // Write data
    input  wire logic        hready,          // Bus ready
    output var  logic [31:0] hrdata,          // Read data
    output var  logic        hreadyout,       // Always ready
    output var  logic        hresp,           // Always OKAY
    input  wire logic        conv_step,       // Conversion done pulse
    output var  logic        chan0_active,    // Channel zero enable
    output var  logic        chan1_active,    // Channel one enable
    output var  logic        cur_chan,        // Channel now converting
    output var  logic        cur_valid,       // A channel is converting
    output var  logic [1:0]  cur_setup_index, // Setup for the converter
    output var  logic [4:0]  cur_plus_sel,    // Positive input route
    output var  logic [4:0]  cur_minus_sel,   // Negative input route
    output var  logic        cur_route_legal  // Both codes documented
);
    logic [15:0] ch0_map_reg;   // Channel zero map
    logic [15:0] ch1_map_reg;   // Channel one map
    logic [15:0] ch0_next;      // Channel zero map after pending write
    logic [15:0] ch1_next;      // Channel one map after pending write
    logic        wr0_reg;       // Data phase writes channel zero
    logic        wr1_reg;       // Data phase writes channel one
    logic        addr_ok;       // Valid address phase this cycle
    logic        seq_chan;      // Owner from the sequencer
    logic        seq_busy;      // Sequencer has an owner
    logic [15:0] sel_map;       // Map of the owner
    logic        post_reset_reg; // High until the first edge after reset

    // Masks reserved bits so they always read as zero
    function automatic logic [15:0] clean(input logic [31:0] d);
        return d[15:0] & chan_map_pkg::MAP_WMASK;
    endfunction

    // True for the documented input codes
    function automatic logic legal(input logic [4:0] c);
        return (c <= chan_map_pkg::IN_LAST) || (c == chan_map_pkg::IN_REF_POS) ||
               (c == chan_map_pkg::IN_REF_NEG);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    assign addr_ok  = hsel && htrans[1] && hready;
    assign ch0_next = wr0_reg ? clean(hwdata) : ch0_map_reg;
    assign ch1_next = wr1_reg ? clean(hwdata) : ch1_map_reg;

    // Address phase capture of writes; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr0_reg <= 1'b0;
            wr1_reg <= 1'b0;
        end else begin
            wr0_reg <= addr_ok && hwrite && (haddr == chan_map_pkg::CH0_ADDR);
            wr1_reg <= addr_ok && hwrite && (haddr == chan_map_pkg::CH1_ADDR);
        end
    end

    // Read data taken from the post-write value so a read right after a
    // write never returns stale contents; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok && !hwrite && (haddr == chan_map_pkg::CH0_ADDR)) begin
            hrdata <= {16'h0000, ch0_next};   // [RULE_01]
        end else if (addr_ok && !hwrite && (haddr == chan_map_pkg::CH1_ADDR)) begin
            hrdata <= {16'h0000, ch1_next};   // [RULE_01]
        end else begin
            hrdata <= 32'h00000000;
        end
    end

    // Zero wait state, never an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Map registers; reserved bits are forced to zero whatever the host
    // writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ch0_map_reg <= chan_map_pkg::CH0_RESET;   // [RULE_11]
            ch1_map_reg <= chan_map_pkg::CH1_RESET;   // [RULE_02]
        end else begin
            ch0_map_reg <= ch0_next;                  // [RULE_05]
            ch1_map_reg <= ch1_next;                  // [RULE_02]
        end
    end

    // Marks the first edge after reset for checking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_reset_reg <= 1'b1;
        end else begin
            post_reset_reg <= 1'b0;
        end
    end

    // Enable outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan0_active <= chan_map_pkg::CH0_RESET[chan_map_pkg::EN_BIT];
            chan1_active <= chan_map_pkg::CH1_RESET[chan_map_pkg::EN_BIT];
        end else begin
            chan0_active <= ch0_next[chan_map_pkg::EN_BIT];   // [RULE_11]
            chan1_active <= ch1_next[chan_map_pkg::EN_BIT];   // [RULE_03]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and routing
    chan_sequencer u_seq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en0     (ch0_map_reg[chan_map_pkg::EN_BIT]),
        .en1     (ch1_map_reg[chan_map_pkg::EN_BIT]),
        .step    (conv_step),
        .chan    (seq_chan),
        .busy    (seq_busy)
    );

    assign sel_map = seq_chan ? ch1_map_reg : ch0_map_reg;

    // Owner's setup and inputs drive the converter; undocumented codes pass
    // through but are flagged, since their routing is undefined
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_chan        <= 1'b0;
            cur_valid       <= 1'b0;
            cur_setup_index <= 2'h0;
            cur_plus_sel    <= 5'h00;
            cur_minus_sel   <= 5'h00;
            cur_route_legal <= 1'b0;
        end else begin
            cur_chan        <= seq_chan;                                   // [RULE_04]
            cur_valid       <= seq_busy;
            // The setup index selects the whole setup group used by this channel
            cur_setup_index <=
                sel_map[chan_map_pkg::SETUP_HI:chan_map_pkg::SETUP_LO]; // [RULE_06] [RULE_07]
            cur_plus_sel    <= sel_map[chan_map_pkg::PLUS_HI:chan_map_pkg::PLUS_LO];   // [RULE_12]
            cur_minus_sel   <= sel_map[chan_map_pkg::MINUS_HI:chan_map_pkg::MINUS_LO]; // [RULE_09]
            cur_route_legal <= legal(sel_map[chan_map_pkg::PLUS_HI:chan_map_pkg::PLUS_LO]) &&
                               legal(sel_map[chan_map_pkg::MINUS_HI:chan_map_pkg::MINUS_LO]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_width_zero;
        @(posedge hclk) disable iff (!hresetn)
        hrdata[31:16] == 16'h0000;
    endproperty
    a_width_zero: assert property (p_width_zero) else $error("upper read bits set"); // [RULE_01]

    property p_ch1_reset;
        @(posedge hclk) disable iff (!hresetn)
        post_reset_reg |-> (ch1_map_reg == chan_map_pkg::CH1_RESET) && !chan1_active;
    endproperty
    a_ch1_reset: assert property (p_ch1_reset) else $error("channel one reset wrong"); // [RULE_02]

    property p_en1_write;
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && hwrite && haddr == chan_map_pkg::CH1_ADDR) ##1 hwdata[chan_map_pkg::EN_BIT]
            |=> chan1_active && ch1_map_reg[chan_map_pkg::EN_BIT];
    endproperty
    a_en1_write: assert property (p_en1_write) else $error("channel one enable lost"); // [RULE_03]

    property p_seq_step;
        @(posedge hclk) disable iff (!hresetn)
        (ch0_map_reg[chan_map_pkg::EN_BIT] && ch1_map_reg[chan_map_pkg::EN_BIT] &&
         conv_step && seq_busy)
            |=> (seq_chan != $past(seq_chan)) ##1 (cur_chan == $past(seq_chan));
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("enabled channels not sequenced"); // [RULE_04]

    property p_reserved;
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite) |=> (hrdata[15:0] & ~chan_map_pkg::MAP_WMASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // [RULE_05]

    property p_setup_route;
        @(posedge hclk) disable iff (!hresetn)
        seq_busy |=> cur_valid &&
            (cur_setup_index == $past(sel_map[chan_map_pkg::SETUP_HI:chan_map_pkg::SETUP_LO]));
    endproperty
    a_setup_route: assert property (p_setup_route) else $error("setup index not routed"); // [RULE_06]

    property p_minus_route;
        @(posedge hclk) disable iff (!hresetn)
        seq_busy |=> cur_minus_sel ==
            $past(sel_map[chan_map_pkg::MINUS_HI:chan_map_pkg::MINUS_LO]);
    endproperty
    a_minus_route: assert property (p_minus_route) else $error("negative route wrong"); // [RULE_09]

    property p_ch0_reset;
        @(posedge hclk) disable iff (!hresetn)
        post_reset_reg |-> ch0_map_reg[chan_map_pkg::EN_BIT] ##2 (cur_valid && !cur_chan);
    endproperty
    a_ch0_reset: assert property (p_ch0_reset) else $error("channel zero not default"); // [RULE_11]

    property p_plus_route;
        @(posedge hclk) disable iff (!hresetn)
        seq_busy |=> cur_plus_sel ==
            $past(sel_map[chan_map_pkg::PLUS_HI:chan_map_pkg::PLUS_LO]);
    endproperty
    a_plus_route: assert property (p_plus_route) else $error("positive route wrong"); // [RULE_12]
endmodule // chan_map_regs
`default_nettype wire

// file: hw/chan_sequencer.sv
// Steps conversion ownership across the enabled channels
`timescale 1ns/100ps
`default_nettype none
module chan_sequencer (
    input  wire logic hclk,      // Bus clock
    input  wire logic hresetn,   // Asynchronous reset, active low
    input  wire logic en0,       // Channel zero enabled
    input  wire logic en1,       // Channel one enabled
    input  wire logic step,      // Conversion finished, move on
    output var  logic chan,      // Channel now owning the converter
    output var  logic busy       // Some channel is enabled
);
    chan_map_pkg::seq_state_t state_reg;   // Current owner
    chan_map_pkg::seq_state_t state_next;  // Next owner

    ////////////////////////////////////////////////////////////////////////
    // Next owner: a disabled owner is left at once, otherwise the
    // converter moves on only at the end of a conversion
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            chan_map_pkg::SEQ_IDLE: begin
                if (en0) begin
                    state_next = chan_map_pkg::SEQ_CH0;
                end else if (en1) begin
                    state_next = chan_map_pkg::SEQ_CH1;
                end
            end
            chan_map_pkg::SEQ_CH0: begin
                if (!en0) begin
                    state_next = en1 ? chan_map_pkg::SEQ_CH1 : chan_map_pkg::SEQ_IDLE;
                end else if (step && en1) begin
                    state_next = chan_map_pkg::SEQ_CH1;   // [RULE_04]
                end
            end
            chan_map_pkg::SEQ_CH1: begin
                if (!en1) begin
                    state_next = en0 ? chan_map_pkg::SEQ_CH0 : chan_map_pkg::SEQ_IDLE;
                end else if (step && en0) begin
                    state_next = chan_map_pkg::SEQ_CH0;   // [RULE_04]
                end
            end
            default: begin
                state_next = chan_map_pkg::SEQ_IDLE;
            end
        endcase
    end

    // Owner register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= chan_map_pkg::SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign chan = (state_reg == chan_map_pkg::SEQ_CH1);
    assign busy = (state_reg != chan_map_pkg::SEQ_IDLE);
endmodule // chan_sequencer
`default_nettype wire

// file: testbench/adc_channel_map_registers_bench.sv
// Self-checking bench for the channel map register bank
`timescale 1ns/100ps
`default_nettype none
module adc_channel_map_registers_bench;
    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic        hclk;            // 20 MHz bus clock
    logic        hresetn;         // Active-low reset
    logic        hsel;            // Slave select
    logic [31:0] haddr;           // Byte address
    logic [1:0]  htrans;          // Transfer type
    logic        hwrite;          // High for a write
    logic [2:0]  hsize;           // Always a word
    logic [31:0] hwdata;          // Write data
    logic [31:0] hrdata;          // Read data
    logic        hreadyout;       // Slave ready, fed back as bus ready
    logic        hresp;           // Response, must stay OKAY
    logic        conv_step;       // End-of-conversion pulse
    logic        chan0_active;    // Channel zero enable out
    logic        chan1_active;    // Channel one enable out
    logic        cur_chan;        // Owning channel
    logic        cur_valid;       // Some channel owns the converter
    logic [1:0]  cur_setup_index; // Owner's setup
    logic [4:0]  cur_plus_sel;    // Owner's positive route
    logic [4:0]  cur_minus_sel;   // Owner's negative route
    logic        cur_route_legal; // Both route codes documented
    logic [31:0] exp_q[$];        // Expected read data, oldest first
    logic        rd_pend;         // A read data phase is running
    int          miscompares;     // Mismatch count
    int          n_tests;         // Comparison count
    int          cycles;          // Cycles since start, for the hang limit
    integer      seed;            // Random seed
    logic [31:0] rnd;             // Random write data
    // Every documented input code, walked through both selectors
    localparam logic [4:0] CODES [0:6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16};

    ////////////////////////////////////////////////////////////////////////////
    // Design under test
    chan_map_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_step(conv_step),
        .chan0_active(chan0_active), .chan1_active(chan1_active), .cur_chan(cur_chan),
        .cur_valid(cur_valid), .cur_setup_index(cur_setup_index),
        .cur_plus_sel(cur_plus_sel), .cur_minus_sel(cur_minus_sel),
        .cur_route_legal(cur_route_legal)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang limit; the whole run needs well under a thousand cycles
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // One single word transfer; signals held until ready is seen high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // A read leaves its expectation for the monitor
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Route outputs lag the map registers by a couple of edges
    task automatic settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask

    task automatic step;
        @(posedge hclk);
        conv_step <= 1'b1;
        @(posedge hclk);
        conv_step <= 1'b0;
        settle();
    endtask

    task automatic route(input logic v, c, input logic [1:0] s,
                         input logic [4:0] p, m, input logic l);
        check({17'h0, cur_valid, cur_chan, cur_setup_index, cur_plus_sel, cur_minus_sel,
               cur_route_legal}, {17'h0, v, c, s, p, m, l});
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: read data is judged at the end edge of its data phase
    always @(posedge hclk) begin
        if (rd_pend && hreadyout) begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
        if (hreadyout) begin
            rd_pend <= hsel && htrans[1] && !hwrite;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        conv_step = 1'b0;
        rd_pend = 1'b0;
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        seed = 32'h6DB0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        // Reset state: only channel zero converts, negative route on input 1
        check({30'h0, chan0_active, chan1_active}, 32'h2);
        route(1'b1, 1'b0, 2'h0, 5'h00, 5'h01, 1'b1);
        rd(chan_map_pkg::CH0_ADDR, 32'h8001);
        rd(chan_map_pkg::CH1_ADDR, 32'h0001);
        // Random words: reserved bits never stick
        for (int i = 0; i < 8; i++) begin
            // Host keeps the reserved bit at zero; bits 11:10 still vary
            rnd = $random(seed) & 32'hFFFFBFFF;
            bus(1'b1, chan_map_pkg::CH1_ADDR, rnd);
            rd(chan_map_pkg::CH1_ADDR, {16'h0, rnd[15:0] & 16'hB3FF});
        end
        // Unmapped word reads zero and a write there disturbs nothing
        bus(1'b1, chan_map_pkg::CH1_ADDR, 32'h0001);
        bus(1'b1, 32'h48, 32'hFFFF);
        rd(32'h48, 32'h0);
        rd(chan_map_pkg::CH1_ADDR, 32'h0001);
        // One channel alone: a step must not move ownership
        step();
        route(1'b1, 1'b0, 2'h0, 5'h00, 5'h01, 1'b1);
        // Both enabled: every setup and every code on each channel in turn
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, chan_map_pkg::CH0_ADDR,
                {16'h0, 1'b1, 1'b0, i[1:0], 2'h0, CODES[i], CODES[6-i]});
            bus(1'b1, chan_map_pkg::CH1_ADDR,
                {16'h0, 1'b1, 1'b0, ~i[1:0], 2'h0, CODES[6-i], CODES[i]});
            settle();
            route(1'b1, 1'b0, i[1:0], CODES[i], CODES[6-i], 1'b1);
            step();
            route(1'b1, 1'b1, ~i[1:0], CODES[6-i], CODES[i], 1'b1);
            step();
        end
        // Undocumented codes pass through but are flagged
        bus(1'b1, chan_map_pkg::CH0_ADDR, 32'h80B7);
        settle();
        route(1'b1, 1'b0, 2'h0, 5'h05, 5'h17, 1'b0);
        // Dropping the owner hands over without a step
        bus(1'b1, chan_map_pkg::CH0_ADDR, 32'h0001);
        settle();
        check({30'h0, chan0_active, chan1_active}, 32'h1);
        route(1'b1, 1'b1, 2'h1, 5'h00, 5'h16, 1'b1);
        bus(1'b1, chan_map_pkg::CH1_ADDR, 32'h0001);
        settle();
        check({31'h0, cur_valid}, 32'h0);
        test_done();
    end
endmodule // adc_channel_map_registers_bench
`default_nettype wire
